// ==== rtl/dbmcl_motor_ctrl.sv ====
/*
  Control-input decoding for a dual H-bridge driver: drive mode decode,
  bridge output states, sense blanking, fault latch, AHB-Lite registers.
  Assumes all inputs synchronous to sys_clk and nrst from the power monitor.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
// How it works
// - Stepping, phase high, enabled, no fault: pos high, neg low.
// - Stepping, phase low, enabled, no fault: neg high, pos low.
// - Stepping, enable low: bridge current off whatever the phase.
// - Enable high turns bridge on; toggling enables gives off or half-step.
// - Either supply indication low holds all outputs in standby.
// - Over-temperature or over-current forces shutdown with outputs off.
// - Fault stays latched, outputs halted, until power-on reset again.
// - Mode pins select one of six bridge arrangements.
// - All mode pins low is standby; test code must never be applied.
// - Mode fixed at power-up; no switching while running.
// - Stepping uses only the fixed analog blank, no digital blank.
// - DC with digital blank select high blanks three chopping periods.
// - DC with digital blank select low uses only analog blank.
// - Current comparator ignored during blanking.
// - Over-current evaluated only within blank windows.
// - Large DC: decode inputs A, B with PWM; PWM low brakes.
// - Modes without short-brake input treat PWM as high.
// - Small DC: both high brake, one high drives, both low open.
// - PWM on short-brake input alternates drive and brake.
// - Stepping modes ignore the short-brake function.
`timescale 1ns/10ps
`include "dbmcl_cfg.svh"
module dbmcl_motor_ctrl #(
  parameter int CHOP_DIV = `DBMCL_CHOP_DIV,
  parameter int ANA_CYC = `DBMCL_ANA_BLANK_CYC,
  parameter int DIG_PER = `DBMCL_DIG_BLANK_PER
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mode_sel_0,
  input wire logic mode_sel_1,
  input wire logic mode_sel_2,
  input wire logic [3:0] phase_in,
  input wire logic [3:0] enable_in,
  input wire logic [1:0] digital_blank_sel,
  input wire logic logic_supply_ok,
  input wire logic motor_supply_ok,
  input wire logic overtemp_detect,
  input wire logic overcurrent_detect,
  input wire logic [1:0] cc_comp_trip,
  output logic [3:0] bridge_out_pos,
  output logic [3:0] bridge_out_neg,
  output logic [3:0] bridge_out_oe,
  output logic [1:0] current_limit,
  output logic fault_latched
);
  import dbmcl_pkg::*;

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic dbmcl_kind_type pair_kind(input dbmcl_mode_type m,
                                               input logic p);
    dbmcl_kind_type k;
    k = DBMCL_PK_OFF;
    unique case (m)
      DBMCL_MODE_STEPS2, DBMCL_MODE_STEPL: k = DBMCL_PK_STEP;
      DBMCL_MODE_DCL2, DBMCL_MODE_DCS4: k = DBMCL_PK_DC;
      DBMCL_MODE_DCL_STEP, DBMCL_MODE_DCS2_STEP:
        k = p ? DBMCL_PK_STEP : DBMCL_PK_DC;
      // Standby and test keep bridges off
      // Test code kept open like standby
      DBMCL_MODE_TEST, DBMCL_MODE_STANDBY: k = DBMCL_PK_OFF;
    endcase
    return k;
  endfunction

  function automatic logic pair_comb(input dbmcl_mode_type m, input logic p);
    return (m == DBMCL_MODE_DCL2) || (m == DBMCL_MODE_STEPL) ||
           (m == DBMCL_MODE_DCL_STEP && !p);
  endfunction

  function automatic dbmcl_drive_type drive_decode(input dbmcl_kind_type k,
    input logic in1, input logic in2, input logic pwm);
    dbmcl_drive_type d;
    d = '0;
    unique case (k)
      DBMCL_PK_STEP:
      begin
        d.oe = in2;
        d.pos = in2 & in1;
        d.neg = in2 & ~in1;
      end
      DBMCL_PK_DC:
      begin
        d.oe = in1 | in2;
        d.pos = in1 & ~in2 & pwm;
        d.neg = in2 & ~in1 & pwm;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  // ****************************************
  // Chopping reference divider
  // ****************************************
  localparam int CW = $clog2(CHOP_DIV);
  logic [CW-1:0] chop_cnt_ff;
  wire chop_ref_clock = chop_cnt_ff == CW'(CHOP_DIV - 1);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      chop_cnt_ff <= '0;
    else
      chop_cnt_ff <= chop_ref_clock ? '0 : chop_cnt_ff + 1'b1;
  end

  // ****************************************
  // Input sampling and mode capture
  // ****************************************
  logic [3:0] ph_ff;
  logic [3:0] en_ff;
  logic [1:0] dsel_ff;
  dbmcl_mode_type mode_ff;
  dbmcl_state_type state_ff;
  dbmcl_state_type nxt_state;

  // Control inputs taken only on the chopping tick
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_ff <= 4'h0;
      en_ff <= 4'h0;
      dsel_ff <= 2'h0;
    end
    else if (chop_ref_clock)
    begin
      ph_ff <= phase_in;
      en_ff <= enable_in;
      dsel_ff <= digital_blank_sel;
    end
  end

  // Mode pins read once after reset release
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mode_ff <= DBMCL_MODE_STANDBY;
    else if (state_ff == DBMCL_ST_CAPTURE)
      mode_ff <= dbmcl_mode_type'({mode_sel_2, mode_sel_1, mode_sel_0});
  end

  // ****************************************
  // Supervision
  // ****************************************
  logic [1:0] blank_act;
  logic [1:0] oc_seen;
  logic temp_flt_ff;
  logic oc_flt_ff;
  logic soft_stby_ff;
  wire supply_ok = logic_supply_ok & motor_supply_ok;
  // Either detector shuts the outputs down
  wire fault_hit = overtemp_detect | (|oc_seen);
  // Standby while a supply is low
  wire drive_ok = (state_ff == DBMCL_ST_RUN) & supply_ok & ~fault_hit &
                  ~soft_stby_ff;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      // Over-temperature at release goes straight to shutdown; no blank window is open yet, so over-current is not seen
      DBMCL_ST_CAPTURE:
        nxt_state = fault_hit ? DBMCL_ST_FAULT :
                    supply_ok ? DBMCL_ST_RUN : DBMCL_ST_SUPPLY_LOW;
      DBMCL_ST_RUN:
        if (fault_hit)
          nxt_state = DBMCL_ST_FAULT;
        else if (!supply_ok)
          nxt_state = DBMCL_ST_SUPPLY_LOW;
      DBMCL_ST_SUPPLY_LOW:
        if (fault_hit)
          nxt_state = DBMCL_ST_FAULT;
        else if (supply_ok)
          nxt_state = DBMCL_ST_RUN;
      // Only reset leaves the fault state
      DBMCL_ST_FAULT: nxt_state = DBMCL_ST_FAULT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= DBMCL_ST_CAPTURE;
      temp_flt_ff <= 1'b0;
      oc_flt_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      temp_flt_ff <= temp_flt_ff | overtemp_detect;
      oc_flt_ff <= oc_flt_ff | (|oc_seen);
    end
  end

  assign fault_latched = temp_flt_ff | oc_flt_ff;

  // ****************************************
  // Bridge pairs and blanking
  // ****************************************
  dbmcl_kind_type kind_w [2];
  logic [1:0] comb_w;
  logic [1:0] pwm_w;
  logic [3:0] chg_w;
  logic [1:0] clim_ff;
  dbmcl_drive_type nxt_drv [4];
  logic [3:0] oe_ff;
  logic [3:0] pos_ff;
  logic [3:0] neg_ff;

  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    dbmcl_blank_if bif();
    assign kind_w[p] = pair_kind(mode_ff, 1'(p));
    assign comb_w[p] = pair_comb(mode_ff, 1'(p));
    // Separate DC axes see PWM as high
    assign pwm_w[p] = (kind_w[p] == DBMCL_PK_DC && comb_w[p]) ? ph_ff[2 * p + 1] : 1'b1;
    assign bif.chop_tick = chop_ref_clock;
    assign bif.start = drive_ok & (chg_w[2 * p] | chg_w[2 * p + 1]);
    // Stepping pairs never use the digital blank
    assign bif.digital = (kind_w[p] == DBMCL_PK_DC) & dsel_ff[p];
    assign bif.cmp_raw = cc_comp_trip[p];
    assign bif.oc_raw = overcurrent_detect;
    assign blank_act[p] = bif.active;
    assign oc_seen[p] = bif.oc_seen;
    dbmcl_blank_timer #(
      .ANA_CYC(ANA_CYC),
      .DIG_PER(DIG_PER)
    ) u_blank (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .bif(bif)
    );

    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
        clim_ff[p] <= 1'b0;
      else
        clim_ff[p] <= bif.cmp_gated;
    end
  end

  for (genvar b = 0; b < 4; b++)
  begin : g_bridge
    localparam int P = b / 2;
    // Combined pairs follow the lead bridge's pins
    wire [1:0] src = comb_w[P] ? 2'(2 * P) : 2'(b);
    // PWM input alternates drive and brake
    assign nxt_drv[b] = drive_ok ? drive_decode(kind_w[P], ph_ff[src], en_ff[src],
                                                pwm_w[P]) : '0;
    assign chg_w[b] = nxt_drv[b] != {oe_ff[b], pos_ff[b], neg_ff[b]};

    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
        {oe_ff[b], pos_ff[b], neg_ff[b]} <= 3'h0;
      else
        {oe_ff[b], pos_ff[b], neg_ff[b]} <= nxt_drv[b];
    end
  end

  assign bridge_out_oe = oe_ff;
  assign bridge_out_pos = pos_ff;
  assign bridge_out_neg = neg_ff;
  assign current_limit = clim_ff;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic wr_ff;
  logic [7:0] wa_ff;
  logic [31:0] rdata_ff;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  wire ap = hsel & hready & htrans[1];

  always_comb
  begin
    status_word = 32'h0;
    status_word[`DBMCL_ST_STATE +: 2] = state_ff;
    status_word[`DBMCL_ST_MODE +: 3] = mode_ff;
    status_word[`DBMCL_ST_TEMP] = temp_flt_ff;
    status_word[`DBMCL_ST_OC] = oc_flt_ff;
    status_word[`DBMCL_ST_SUPPLY] = supply_ok;
    status_word[`DBMCL_ST_BLANK +: 2] = blank_act;
    status_word[`DBMCL_ST_CLIM +: 2] = clim_ff;
  end

  // Unmapped words read zero and ignore writes
  assign rd_mux = (haddr[7:0] == `DBMCL_ADDR_STATUS) ? status_word :
                  (haddr[7:0] == `DBMCL_ADDR_CTRL) ? {31'h0, soft_stby_ff} :
                  32'h0;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h0;
      rdata_ff <= 32'h0;
    end
    else
    begin
      wr_ff <= ap & hwrite;
      wa_ff <= haddr[7:0];
      rdata_ff <= (ap && !hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      soft_stby_ff <= `DBMCL_CTRL_RESET;
    else if (wr_ff && wa_ff == `DBMCL_ADDR_CTRL)
      soft_stby_ff <= hwdata[`DBMCL_CTRL_STBY];
  end

  // Zero wait states; hsize unused since only whole words exist
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  wire step0 = kind_w[0] == DBMCL_PK_STEP && !comb_w[0];
  wire dcl0 = kind_w[0] == DBMCL_PK_DC && comb_w[0];

  step_pos_a: assert property (
    drive_ok && step0 && ph_ff[0] && en_ff[0] |=> oe_ff[0] && pos_ff[0] && !neg_ff[0])
    else $error("stepping positive drive wrong");
  step_neg_a: assert property (
    drive_ok && step0 && !ph_ff[0] && en_ff[0] |=> oe_ff[0] && !pos_ff[0] && neg_ff[0])
    else $error("stepping negative drive wrong");
  step_off_a: assert property (
    step0 && !en_ff[1] |=> !oe_ff[1]) else $error("disabled bridge still driven");
  enable_on_a: assert property (
    drive_ok && step0 && en_ff[1] |=> oe_ff[1]) else $error("enabled bridge not on");
  supply_stby_a: assert property (
    !supply_ok |=> oe_ff == 4'h0) else $error("outputs on with supply low");
  fault_off_a: assert property (
    fault_hit |=> oe_ff == 4'h0 && state_ff == DBMCL_ST_FAULT)
    else $error("fault did not shut down");
  fault_hold_a: assert property (
    state_ff == DBMCL_ST_FAULT |=> state_ff == DBMCL_ST_FAULT && oe_ff == 4'h0)
    else $error("fault released without reset");
  mode_fixed_a: assert property (
    state_ff != DBMCL_ST_CAPTURE |=> $stable(mode_ff)) else $error("mode changed");
  test_off_a: assert property (
    mode_ff == DBMCL_MODE_TEST && state_ff != DBMCL_ST_CAPTURE |=> oe_ff == 4'h0)
    else $error("test mode drives outputs");
  dc_brake_a: assert property (
    drive_ok && dcl0 && !ph_ff[1] && (ph_ff[0] || en_ff[0])
    |=> oe_ff[1:0] == 2'h3 && pos_ff[1:0] == 2'h0 && neg_ff[1:0] == 2'h0)
    else $error("large DC brake wrong");
  dc4_drive_a: assert property (
    drive_ok && mode_ff == DBMCL_MODE_DCS4 && ph_ff[2] && !en_ff[2]
    |=> oe_ff[2] && pos_ff[2] && !neg_ff[2]) else $error("small DC drive wrong");
  oc_gate_a: assert property (
    state_ff == DBMCL_ST_RUN && blank_act == 2'h0 && !overtemp_detect
    |=> state_ff != DBMCL_ST_FAULT) else $error("fault outside blank window");
  sync_tick_a: assert property (
    !chop_ref_clock |=> $stable(ph_ff) && $stable(en_ff))
    else $error("inputs sampled off the chopping tick");
endmodule // dbmcl_motor_ctrl

// ==== rtl/dbmcl_cfg.svh ====
/*
  Constants of the dual bridge control logic: bus offsets, field positions,
  reset values and timing counts. Assumes a 40 MHz system clock.
*/
`ifndef DBMCL_CFG_SVH
`define DBMCL_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define DBMCL_ADDR_STATUS 8'h00
`define DBMCL_ADDR_CTRL 8'h04
`define DBMCL_CTRL_STBY 0
`define DBMCL_CTRL_RESET 1'h0
`define DBMCL_ST_STATE 0
`define DBMCL_ST_MODE 4
`define DBMCL_ST_TEMP 8
`define DBMCL_ST_OC 9
`define DBMCL_ST_SUPPLY 10
`define DBMCL_ST_BLANK 12
`define DBMCL_ST_CLIM 14

// ****************************************
// Timing
// ****************************************
`define DBMCL_SYS_CLK_HZ 40000000
`define DBMCL_SYS_CLK_NS 25
`define DBMCL_CHOP_HZ 100000
`define DBMCL_CHOP_DIV (`DBMCL_SYS_CLK_HZ / `DBMCL_CHOP_HZ)
`define DBMCL_ANA_BLANK_NS 300
`define DBMCL_ANA_BLANK_CYC \
  ((`DBMCL_ANA_BLANK_NS + `DBMCL_SYS_CLK_NS - 1) / `DBMCL_SYS_CLK_NS)
`define DBMCL_DIG_BLANK_PER 3

`endif

// ==== rtl/dbmcl_pkg.sv ====
/*
  Types shared by the dual bridge control logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dbmcl_pkg;

  typedef enum logic [1:0] {
    DBMCL_ST_CAPTURE = 2'h0,
    DBMCL_ST_RUN = 2'h1,
    DBMCL_ST_FAULT = 2'h3,
    DBMCL_ST_SUPPLY_LOW = 2'h2
  } dbmcl_state_type;

  // Encoded as {mode_sel_2, mode_sel_1, mode_sel_0}
  typedef enum logic [2:0] {
    DBMCL_MODE_STANDBY = 3'h0,
    DBMCL_MODE_TEST = 3'h1,
    DBMCL_MODE_DCS2_STEP = 3'h2,
    DBMCL_MODE_DCL_STEP = 3'h3,
    DBMCL_MODE_DCS4 = 3'h4,
    DBMCL_MODE_STEPL = 3'h5,
    DBMCL_MODE_DCL2 = 3'h6,
    DBMCL_MODE_STEPS2 = 3'h7
  } dbmcl_mode_type;

  typedef enum logic [1:0] {
    DBMCL_PK_OFF = 2'h0,
    DBMCL_PK_STEP = 2'h1,
    DBMCL_PK_DC = 2'h2
  } dbmcl_kind_type;

  typedef struct packed {
    logic oe;
    logic pos;
    logic neg;
  } dbmcl_drive_type;

endpackage

// ==== rtl/dbmcl_blank_if.sv ====
/*
  Signals between the control core and one blanking timer.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/10ps
interface dbmcl_blank_if;
  logic chop_tick;
  logic start;
  logic digital;
  logic cmp_raw;
  logic oc_raw;
  logic active;
  logic cmp_gated;
  logic oc_seen;
  modport timer (input chop_tick, start, digital, cmp_raw, oc_raw,
                 output active, cmp_gated, oc_seen);
  modport ctrl (output chop_tick, start, digital, cmp_raw, oc_raw,
                input active, cmp_gated, oc_seen);
endinterface

// ==== rtl/dbmcl_blank_timer.sv ====
/*
  Sense blanking timer for one bridge pair: analog length in system
  cycles or digital length in chopping periods.
  Assumes start is a one-cycle pulse and chop_tick a one-cycle enable.
*/
`timescale 1ns/10ps
`include "dbmcl_cfg.svh"
module dbmcl_blank_timer #(
  parameter int ANA_CYC = `DBMCL_ANA_BLANK_CYC,
  parameter int DIG_PER = `DBMCL_DIG_BLANK_PER
) (
  input wire logic sys_clk,
  input wire logic nrst,
  dbmcl_blank_if.timer bif
);
  import dbmcl_pkg::*;

  localparam int MAXC = (ANA_CYC > DIG_PER) ? ANA_CYC : DIG_PER;
  localparam int CW = $clog2(MAXC + 1);

  logic [CW-1:0] cnt_ff;
  logic dig_ff;
  wire dec_en = dig_ff ? bif.chop_tick : 1'b1;
  wire [CW-1:0] load_val = bif.digital ? CW'(DIG_PER) : CW'(ANA_CYC);

  // Retrigger reloads, so back to back transitions stay covered
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= '0;
      dig_ff <= 1'b0;
    end
    else if (bif.start)
    begin
      cnt_ff <= load_val;
      dig_ff <= bif.digital;
    end
    else if (cnt_ff != '0 && dec_en)
      cnt_ff <= cnt_ff - 1'b1;
  end

  assign bif.active = cnt_ff != '0;
  assign bif.cmp_gated = bif.cmp_raw & ~bif.active;
  // Over-current seen only in the window
  assign bif.oc_seen = bif.oc_raw & bif.active;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence ana_run;
    bif.active [*8];
  endsequence

  cmp_mask_a: assert property (
    bif.active |-> !bif.cmp_gated) else $error("comparator passed while blanking");
  ana_len_a: assert property (
    bif.start && !bif.digital |=> ana_run) else $error("analog blank too short");
  dig_len_a: assert property (
    bif.start && bif.digital |=> bif.active && cnt_ff == 3 && dig_ff)
    else $error("digital blank not three periods");
  dig_hold_a: assert property (
    dig_ff && bif.active && !bif.chop_tick && !bif.start |=> bif.active)
    else $error("digital blank ended off a chopping tick");
  oc_window_a: assert property (
    bif.oc_seen |-> bif.active) else $error("over-current seen outside window");
endmodule // dbmcl_blank_timer

// ==== tb/dbmcl_host_model.sv ====
/*
  Host model: drives the mode, phase and enable pins from commanded values.
  Assumes commands change just after a rising sys_clk edge.
*/
`timescale 1ns/10ps
module dbmcl_host_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] cmd_mode,
  input wire logic [3:0] cmd_phase,
  input wire logic [3:0] cmd_enable,
  output logic mode_sel_0,
  output logic mode_sel_1,
  output logic mode_sel_2,
  output logic [3:0] phase_in,
  output logic [3:0] enable_in
);
  always @(posedge sys_clk)
  begin
    if (!nrst)
      {mode_sel_2, mode_sel_1, mode_sel_0} <= cmd_mode;
    phase_in <= cmd_phase;
    enable_in <= nrst ? cmd_enable : 4'h0;
  end
endmodule // dbmcl_host_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the dual bridge control logic.
  Assumes the host model in tb/ and a chopping divider shortened to 8.
*/
`timescale 1ns/10ps
module testbench;
  localparam int CDIV = 8;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, flt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, blank_sel, comp, climit;
  logic [2:0] hsize, cmd_mode;
  logic [3:0] cmd_phase, cmd_enable, phase, enable, pos, neg, oe;
  logic vcc_ok, vm_ok, otemp, ocur, m0, m1, m2;
  int fails = 0;
  int tests_run = 0;
  wire [11:0] outs = {oe, pos, neg};

  dbmcl_host_model u_host (.sys_clk(sys_clk), .nrst(nrst), .cmd_mode(cmd_mode),
    .cmd_phase(cmd_phase), .cmd_enable(cmd_enable), .mode_sel_0(m0),
    .mode_sel_1(m1), .mode_sel_2(m2), .phase_in(phase), .enable_in(enable));
  dbmcl_motor_ctrl #(.CHOP_DIV(CDIV)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mode_sel_0(m0), .mode_sel_1(m1), .mode_sel_2(m2),
    .phase_in(phase), .enable_in(enable), .digital_blank_sel(blank_sel),
    .logic_supply_ok(vcc_ok), .motor_supply_ok(vm_ok), .overtemp_detect(otemp),
    .overcurrent_detect(ocur), .cc_comp_trip(comp), .bridge_out_pos(pos),
    .bridge_out_neg(neg), .bridge_out_oe(oe), .current_limit(climit),
    .fault_latched(flt));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Pins are sampled only on chopping ticks, so allow two tick periods
  task automatic drive(input logic [3:0] ph, input logic [3:0] en);
    cmd_phase <= ph;
    cmd_enable <= en;
    ticks(2 * CDIV + 2);
  endtask
  task automatic do_reset(input logic [2:0] m);
    nrst <= 1'b0;
    cmd_mode <= m;
    cmd_phase <= 4'h0;
    cmd_enable <= 4'h0;
    ticks(20);
    nrst <= 1'b1;
    ticks(3);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic final_report;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_step;
    logic [3:0] ph [4] = '{4'hF, 4'h0, 4'hA, 4'h5};
    logic [3:0] en [4] = '{4'hF, 4'hF, 4'h5, 4'hA};
    do_reset(3'h7);
    for (int i = 0; i < 4; i++)
    begin
      drive(ph[i], en[i]);
      check(32'({en[i], ph[i] & en[i], ~ph[i] & en[i]}), 32'(outs));
    end
    $display("test step done");
  endtask
  task automatic t_modes;
    for (int k = 0; k < 8; k++)
    begin
      do_reset(3'(k));
      drive(4'hF, 4'hF);
      ahb(1'b0, 8'h00, 32'h0);
      check(32'(k), 32'(rd[6:4]));
      if (k < 2)
        check(32'h0, 32'(outs));
    end
    $display("test modes done");
  endtask
  task automatic t_dcl;
    // Entry: {in1, in2, pwm, oe, pos, neg}
    logic [5:0] tb [8] = '{6'h1D, 6'h2E, 6'h3C, 6'h08, 6'h24, 6'h14, 6'h00, 6'h34};
    do_reset(3'h6);
    for (int i = 0; i < 8; i++)
    begin
      drive({tb[i][3], tb[i][5], tb[i][3], tb[i][5]}, {4{tb[i][4]}});
      check(32'({{4{tb[i][2]}}, {4{tb[i][1]}}, {4{tb[i][0]}}}), 32'(outs));
    end
    do_reset(3'h4);
    drive(4'h5, 4'h3);
    check(32'h742, 32'(outs));
    $display("test dc done");
  endtask
  task automatic t_supply;
    do_reset(3'h7);
    drive(4'hF, 4'hF);
    vm_ok <= 1'b0;
    ticks(3);
    check(32'h0, 32'(outs));
    ahb(1'b0, 8'h00, 32'h0);
    check(32'h2, 32'(rd[1:0]));
    vm_ok <= 1'b1;
    vcc_ok <= 1'b0;
    ticks(3);
    check(32'h0, 32'(outs));
    vcc_ok <= 1'b1;
    drive(4'hF, 4'hF);
    check(32'hFF0, 32'(outs));
    $display("test supply done");
  endtask
  task automatic t_fault;
    do_reset(3'h7);
    drive(4'hF, 4'hF);
    ticks(4 * CDIV);
    ocur <= 1'b1;
    ticks(2);
    ocur <= 1'b0;
    ticks(2);
    check(32'h0, 32'(flt));
    ocur <= 1'b1;
    drive(4'h0, 4'hF);
    ocur <= 1'b0;
    check(32'h1000, 32'({flt, outs}));
    drive(4'hF, 4'hF);
    check(32'h1000, 32'({flt, outs}));
    do_reset(3'h7);
    drive(4'hF, 4'hF);
    check(32'h0FF0, 32'({flt, outs}));
    otemp <= 1'b1;
    ticks(3);
    otemp <= 1'b0;
    ticks(3);
    check(32'h1000, 32'({flt, outs}));
    $display("test fault done");
  endtask
  task automatic t_blank(input logic [2:0] m, input logic s, input int lo, input int hi);
    int n;
    n = 0;
    do_reset(m);
    blank_sel <= {s, s};
    comp <= 2'h3;
    drive(4'h3, 4'h0);
    cmd_phase <= 4'h2;
    cmd_enable <= 4'h1;
    while (neg[0] !== 1'b1) @(posedge sys_clk);
    // Limit flag from before the retrigger is still visible here
    @(posedge sys_clk);
    while (climit[0] !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (n < lo || n > hi)
      $display("blank length %0d cycles", n);
    check(32'h1, 32'(n >= lo && n <= hi));
    comp <= 2'h0;
    $display("test blank done");
  endtask
  task automatic t_regs;
    do_reset(3'h7);
    ahb(1'b0, 8'h04, 32'h0);
    check(32'h0, rd);
    ahb(1'b0, 8'h00, 32'h0);
    check(32'h401, {21'h0, rd[10], 8'h0, rd[1:0]});
    drive(4'hF, 4'hF);
    ahb(1'b1, 8'h04, 32'h1);
    check(32'h0, 32'(hresp));
    ticks(3);
    check(32'h0, 32'(outs));
    ahb(1'b0, 8'h04, 32'h0);
    check(32'h1, rd);
    ahb(1'b1, 8'h08, 32'hFFFFFFFF);
    ahb(1'b0, 8'h08, 32'h0);
    check(32'h0, rd);
    ahb(1'b1, 8'h04, 32'h0);
    drive(4'hF, 4'hF);
    check(32'hFF0, 32'(outs));
    $display("test regs done");
  endtask

  // ****************************************
  // Run
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    final_report;
  end
  initial
  begin
    {nrst, hsel, hwrite, otemp, ocur} = 5'h0;
    {vcc_ok, vm_ok} = 2'h3;
    {haddr, hwdata} = 64'h0;
    {htrans, blank_sel, comp} = 6'h0;
    hsize = 3'h2;
    cmd_mode = 3'h7;
    {cmd_phase, cmd_enable} = 8'h0;
    t_step;
    t_modes;
    t_dcl;
    t_supply;
    t_fault;
    t_blank(3'h7, 1'b1, 10, 15);
    t_blank(3'h6, 1'b0, 10, 15);
    t_blank(3'h6, 1'b1, 3 * CDIV - 4, 3 * CDIV + 3);
    t_regs;
    final_report;
  end
endmodule // testbench
